// ---- common/rdcc_pkg.sv ----
package rdcc_pkg;

	// ****************************************
	// Widths, limits and defaults
	// ****************************************
	localparam int          ADDR_W       = 14;
	localparam int          CV_W         = 8;
	localparam int          STAT_W       = 5;
	localparam logic [13:0] LOCO_MIN     = 14'h0001;
	localparam logic [13:0] LOCO_MAX     = 14'h270f;
	localparam logic [13:0] LOCO_DEF     = 14'h0003;
	localparam logic [13:0] CV_VAL_MAX   = 14'h00ff;
	localparam logic [7:0]  CV_NUM_ADDR  = 8'h01;
	localparam logic [7:0]  CV_NUM_LOSS  = 8'h0b;
	localparam logic [7:0]  CV_DEF       = 8'h00;
	localparam logic [7:0]  LSEC_SAT     = 8'hff;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ      = 50_000_000;
	localparam int SEC_CYC     = CLK_HZ;
	localparam int HORN_DLY_MS = 1000;
	localparam int HORN_CYC    = (CLK_HZ / 1000) * HORN_DLY_MS;

	// ****************************************
	// Register map and status bits
	// ****************************************
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_MASK   = 8'h04;
	localparam logic [7:0] REG_STATE  = 8'h08;
	localparam logic [7:0] REG_ADDR   = 8'h0c;
	localparam logic [7:0] REG_LOSS   = 8'h10;
	localparam int ST_PROG_OK  = 0;
	localparam int ST_PROG_BAD = 1;
	localparam int ST_LOSS     = 2;
	localparam int ST_HORN_OFF = 3;
	localparam int ST_THERMAL  = 4;

	// ****************************************
	// Carriers
	// ****************************************
	typedef enum logic [2:0] {
		RDCC_CMD_THROTTLE = 3'b001,
		RDCC_CMD_PROG     = 3'b010,
		RDCC_CMD_RESTORE  = 3'b100
	} rdcc_kind_t;

	typedef struct packed {
		logic              valid;
		rdcc_kind_t        kind;
		logic [13:0]       addr;
		logic              broadcast;
		logic [7:0]        cv_num;
		logic [13:0]       cv_val;
		logic [7:0]        speed;
		logic              horn;
	} rdcc_cmd_t;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [7:0]        paddr;
		logic [31:0]       pwdata;
	} rdcc_apb_req_t;

	typedef struct packed {
		logic              pready;
		logic [31:0]       prdata;
		logic              pslverr;
	} rdcc_apb_rsp_t;

endpackage

// ---- sim/rdcc_throttle.sv ----
`timescale 1ns/1ps
module rdcc_throttle (
	// Clock
	input  wire logic                pclk,
	// Radio command word
	output      rdcc_pkg::rdcc_cmd_t cmd
);
	import rdcc_pkg::*;

	initial cmd = '0;

	// ****************************************
	// One command word per call
	// ****************************************
	task automatic send(input rdcc_kind_t k, input logic [13:0] a,
		input logic b, input logic [7:0] n, input logic [13:0] v,
		input logic [7:0] s, input logic h);
		rdcc_cmd_t c;
		c = '{1'b1, k, a, b, n, v, s, h};
		@(posedge pclk);
		cmd <= c;
		@(posedge pclk);
		// Idle link shows garbage, never the old word
		c = ~c;
		c.valid = 1'b0;
		cmd <= c;
	endtask
endmodule // rdcc_throttle

// ---- sim/tb.sv ----
`timescale 1ns/1ps
module tb;
	import rdcc_pkg::*;

	logic          pclk     = 1'b0;
	logic          presetn  = 1'b0;
	logic          overtemp = 1'b0;
	rdcc_apb_req_t req      = '0;
	rdcc_apb_rsp_t rsp;
	rdcc_cmd_t     cmd;
	logic [7:0]    speed_o;
	logic          horn_o;
	logic          drv_en_o;
	logic          irq;
	logic [31:0]   rd;
	logic          err;
	int            n_fail   = 0;
	int            checks   = 0;

	always #10 pclk = ~pclk;

	rdcc_top #(.NUM_CV(16), .SEC_CYCS(20), .HORN_CYCS(10)) rdcc_top_i (
		.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
		.cmd(cmd), .overtemp(overtemp), .speed_o(speed_o),
		.horn_o(horn_o), .drv_en_o(drv_en_o), .irq(irq));
	rdcc_throttle rdcc_throttle_i (.pclk(pclk), .cmd(cmd));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic end_of_test;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int i;
		@(posedge pclk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		req.penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (rsp.pready === 1'b1)
				break;
		end
		if (i == 20) begin
			n_fail++;
			$display("unexpected at %0t: no pready", $time);
			end_of_test();
		end
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask

	task automatic thr(input logic [13:0] a, input logic [7:0] s,
		input logic h);
		rdcc_throttle_i.send(RDCC_CMD_THROTTLE, a, 1'b0, 8'h0, 14'h0, s, h);
	endtask

	task automatic prog(input logic [13:0] a, input logic b,
		input logic [7:0] n, input logic [13:0] v);
		rdcc_throttle_i.send(RDCC_CMD_PROG, a, b, n, v, 8'h0, 1'b0);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	logic [13:0] tv [5] = '{14'h2710, 14'h0, 14'h100, 14'hff, 14'h270f};
	logic [7:0]  tn [5] = '{8'h01, 8'h01, 8'h02, 8'h02, 8'h01};
	logic [1:0]  ts [5] = '{2'h2, 2'h2, 2'h2, 2'h1, 2'h1};

	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rdcc_throttle_i.send(RDCC_CMD_RESTORE, 14'h0, 1'b1, 8'h0, 14'h0,
			8'h0, 1'b0);
		rdchk(REG_ADDR, 32'h3);
		rdchk(REG_LOSS, 32'h0);
		apb(1'b1, REG_MASK, 32'h1f);
		rdchk(REG_MASK, 32'h1f);
		apb(1'b0, REG_STATUS, 32'h0);
		thr(14'h3, 8'h40, 1'b1);
		thr(14'h5, 8'h00, 1'b0);
		repeat (20) @(posedge pclk);
		chk(32'(horn_o), 32'h1);
		chk(32'(speed_o), 32'h40);
		rdchk(REG_ADDR, 32'h3);
		thr(14'h3, 8'h40, 1'b1);
		repeat (60) @(posedge pclk);
		chk(32'(horn_o), 32'h0);
		chk(32'(speed_o), 32'h40);
		chk(32'(irq), 32'h1);
		rdchk(REG_STATUS, 32'h8);
		@(posedge pclk);
		chk(32'(irq), 32'h0);
		prog(14'h63, 1'b1, CV_NUM_LOSS, 14'h2);
		rdchk(REG_LOSS, 32'h2);
		prog(14'h63, 1'b0, CV_NUM_LOSS, 14'h5);
		rdchk(REG_LOSS, 32'h2);
		apb(1'b0, REG_STATUS, 32'h0);
		for (int i = 0; i < 5; i++) begin
			prog(14'h3, i == 0, tn[i], tv[i]);
			apb(1'b0, REG_STATUS, 32'h0);
			chk(rd & 32'h3, 32'(ts[i]));
		end
		rdchk(REG_ADDR, 32'h270f);
		thr(14'h270f, 8'h33, 1'b0);
		apb(1'b0, REG_STATUS, 32'h0);
		repeat (24) @(posedge pclk);
		chk(32'(speed_o), 32'h33);
		repeat (20) @(posedge pclk);
		chk(32'(speed_o), 32'h0);
		rdchk(REG_STATUS, 32'h4);
		overtemp <= 1'b1;
		@(posedge pclk);
		overtemp <= 1'b0;
		repeat (10) @(posedge pclk);
		chk(32'(drv_en_o), 32'h0);
		rdchk(REG_STATUS, 32'h10);
		rdchk(REG_STATE, 32'h400);
		apb(1'b0, 8'h20, 32'h0);
		chk(32'(err), 32'h1);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(REG_ADDR, 32'h270f);
		rdchk(REG_LOSS, 32'h2);
		chk(32'(drv_en_o), 32'h1);
		end_of_test();
	end
endmodule // tb

// ---- verilog/rdcc_top.sv ----
`timescale 1ns/1ps
// Behaviour
// R1: Timeout setting zero keeps the loco running after commands stop.
// R2: Nonzero timeout stops the loco once that many seconds pass.
// R3: Silence after a horn-on command turns the horn off after a delay.
// R4: Broadcast programming writes settings regardless of loco address.
// R5: Throttle sends target address before any addressed programming write.
// R6: Addressed programming writes with another address are discarded.
// R7: Settings survive power removal and do not depend on throttle.
// R8: Setting one holds the loco address used for command matching.
// R9: Loco address accepts 1 through 9999 only.
// R10: Factory or restored loco address is 3.
// R11: Other settings take eight-bit values 0 through 255.
// R12: Driver overtemperature latches drivers off until power cycle, no buzzer.
// R13: Throttle channel or number changes alone alter no stored setting.
// R14: Loss timer counts whole seconds, restarts on each addressed command; code restarts it on addressed throttle commands only.
// R15: Horn auto-off delay is cancelled by any new valid command.
module rdcc_top #(
	parameter int NUM_CV   = 16,
	parameter int SEC_CYCS = rdcc_pkg::SEC_CYC,
	parameter int HORN_CYCS = rdcc_pkg::HORN_CYC
) (
	// APB
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire rdcc_pkg::rdcc_apb_req_t apb_req,
	output      rdcc_pkg::rdcc_apb_rsp_t apb_rsp,
	// Radio commands and driver sense
	input  wire rdcc_pkg::rdcc_cmd_t     cmd,
	input  wire logic                    overtemp,
	// Locomotive outputs and interrupt
	output      logic [7:0]              speed_o,
	output      logic                    horn_o,
	output      logic                    drv_en_o,
	output      logic                    irq
);
	import rdcc_pkg::*;

	localparam int TW = $clog2(SEC_CYCS + 1);
	localparam int HW = $clog2(HORN_CYCS + 1);
	localparam logic [TW-1:0] TICK_LAST = TW'(SEC_CYCS - 1);
	localparam logic [HW-1:0] HORN_LAST = HW'(HORN_CYCS - 1);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [7:0]        speed_r;
		logic              horn_r;
		logic              drv_en_r;
		logic [TW-1:0]     tick_r;
		logic [7:0]        lsec_r;
		logic              lost_r;
		logic [HW-1:0]     hcnt_r;
		logic              hrun_r;
		logic [STAT_W-1:0] status_r;
		logic [STAT_W-1:0] mask_r;
		logic              irq_r;
		logic              pready_r;
		logic [31:0]       prdata_r;
		logic              pslverr_r;
	} rdcc_state_t;

	rdcc_state_t       s_r;
	rdcc_state_t       s_nxt;
	logic [13:0]       loco_r;
	logic [13:0]       loco_nxt;
	logic [CV_W-1:0]   cv_r   [NUM_CV];
	logic [CV_W-1:0]   cv_nxt [NUM_CV];
	logic              hit;
	logic              thr_hit;
	logic              prog_ok;
	logic              prog_bad;
	logic              loss_evt;
	logic              horn_evt;
	logic              acc;
	logic              done;
	logic              mapped;
	logic [31:0]       rdata;
	logic [STAT_W-1:0] st_set;
	logic [STAT_W-1:0] st_clr;
	logic [7:0]        loss_set;

	function automatic logic reg_known(input logic [7:0] a);
		return a == REG_STATUS || a == REG_MASK || a == REG_STATE ||
			a == REG_ADDR || a == REG_LOSS;
	endfunction

	assign loss_set = cv_r[CV_NUM_LOSS[$clog2(NUM_CV)-1:0]];
	assign hit      = cmd.addr == loco_r; // R8
	assign thr_hit  = cmd.valid && cmd.kind == RDCC_CMD_THROTTLE && hit;
	assign acc      = apb_req.psel && apb_req.penable;
	assign done     = acc && s_r.pready_r;
	assign mapped   = reg_known(apb_req.paddr);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_nxt    = s_r;
		loco_nxt = loco_r;
		cv_nxt   = cv_r;
		prog_ok  = 1'b0;
		prog_bad = 1'b0;
		loss_evt = 1'b0;
		horn_evt = 1'b0;
		rdata    = '0;
		st_clr   = '0;

		// Whole-second loss timer
		if (s_r.tick_r == TICK_LAST) begin // R14
			s_nxt.tick_r = '0;
			if (s_r.lsec_r != LSEC_SAT)
				s_nxt.lsec_r = s_r.lsec_r + 8'h01;
		end else begin
			s_nxt.tick_r = s_r.tick_r + TW'(1);
		end
		if (loss_set != CV_DEF && !s_r.lost_r &&
				s_r.lsec_r >= loss_set && !thr_hit) begin // R1 R2
			loss_evt      = 1'b1;
			s_nxt.lost_r  = 1'b1;
			s_nxt.speed_r = '0;
		end

		// Horn auto-off
		if (s_r.hrun_r) begin
			if (s_r.hcnt_r == HORN_LAST && !cmd.valid) begin // R3
				horn_evt      = 1'b1;
				s_nxt.horn_r  = 1'b0;
				s_nxt.hrun_r  = 1'b0;
			end else begin
				s_nxt.hcnt_r = s_r.hcnt_r + HW'(1);
			end
		end

		// Incoming commands override the timers
		if (cmd.valid) begin
			s_nxt.hcnt_r = '0; // R15
			s_nxt.hrun_r = 1'b0; // R15
			unique case (cmd.kind)
				RDCC_CMD_THROTTLE: begin
					if (hit) begin
						s_nxt.speed_r = cmd.speed;
						s_nxt.horn_r  = cmd.horn;
						s_nxt.hrun_r  = cmd.horn; // R3
						s_nxt.tick_r  = '0; // R14
						s_nxt.lsec_r  = '0; // R14
						s_nxt.lost_r  = 1'b0;
					end
				end
				RDCC_CMD_PROG: begin
					// Addressed writes need a match
					if (cmd.broadcast || hit) begin // R4 R6
						if (cmd.cv_num == CV_NUM_ADDR) begin
							if (cmd.cv_val >= LOCO_MIN &&
									cmd.cv_val <= LOCO_MAX) begin // R9
								loco_nxt = cmd.cv_val;
								prog_ok  = 1'b1;
							end else begin
								prog_bad = 1'b1;
							end
						end else if (cmd.cv_num < 8'(NUM_CV) &&
								cmd.cv_val <= CV_VAL_MAX) begin // R11
							cv_nxt[cmd.cv_num[$clog2(NUM_CV)-1:0]] =
								cmd.cv_val[CV_W-1:0];
							prog_ok = 1'b1;
						end else begin
							prog_bad = 1'b1;
						end
					end
				end
				RDCC_CMD_RESTORE: begin
					if (cmd.broadcast || hit) begin
						loco_nxt = LOCO_DEF; // R10
						for (int i = 0; i < NUM_CV; i++)
							cv_nxt[i] = CV_DEF;
						prog_ok = 1'b1;
					end
				end
				default: prog_bad = 1'b1;
			endcase
		end

		// Thermal latch; no buzzer output exists
		if (overtemp)
			s_nxt.drv_en_r = 1'b0; // R12

		// APB: one wait state, registered answer
		unique case (apb_req.paddr)
			REG_STATUS: rdata = 32'(s_r.status_r);
			REG_MASK:   rdata = 32'(s_r.mask_r);
			REG_STATE:  rdata = {21'h000000, s_r.lost_r, s_r.drv_en_r,
				s_r.horn_r, s_r.speed_r};
			REG_ADDR:   rdata = 32'(loco_r);
			REG_LOSS:   rdata = 32'(loss_set);
			default:    rdata = '0;
		endcase
		if (acc && !s_r.pready_r) begin
			s_nxt.pready_r  = 1'b1;
			s_nxt.prdata_r  = apb_req.pwrite ? '0 : rdata;
			s_nxt.pslverr_r = !mapped;
		end else begin
			s_nxt.pready_r  = 1'b0;
			s_nxt.prdata_r  = '0;
			s_nxt.pslverr_r = 1'b0;
		end
		if (done && apb_req.pwrite && apb_req.paddr == REG_MASK)
			s_nxt.mask_r = apb_req.pwdata[STAT_W-1:0];
		// Clear only what the read returned
		if (done && !apb_req.pwrite && apb_req.paddr == REG_STATUS)
			st_clr = s_r.prdata_r[STAT_W-1:0];

		st_set = '0;
		st_set[ST_PROG_OK]  = prog_ok;
		st_set[ST_PROG_BAD] = prog_bad;
		st_set[ST_LOSS]     = loss_evt;
		st_set[ST_HORN_OFF] = horn_evt;
		st_set[ST_THERMAL]  = overtemp && s_r.drv_en_r;
		s_nxt.status_r = (s_r.status_r & ~st_clr) | st_set;
		s_nxt.irq_r    = |(s_nxt.status_r & s_nxt.mask_r);
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r          <= '0;
			s_r.drv_en_r <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Nonvolatile settings: untouched by reset
	always_ff @(posedge pclk) begin
		loco_r <= loco_nxt; // R7 R13
		cv_r   <= cv_nxt; // R7
	end

	assign apb_rsp.pready  = s_r.pready_r;
	assign apb_rsp.prdata  = s_r.prdata_r;
	assign apb_rsp.pslverr = s_r.pslverr_r;
	assign speed_o  = s_r.speed_r;
	assign horn_o   = s_r.horn_r;
	assign drv_en_o = s_r.drv_en_r;
	assign irq      = s_r.irq_r;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence seq_horn_on;
		thr_hit && cmd.horn;
	endsequence
	sequence seq_silent;
		!cmd.valid [*2];
	endsequence

	chk_zero_no_stop: assert property ( // R1
		loss_set == CV_DEF && !cmd.valid |=> $stable(speed_o))
		else $error("speed changed with zero timeout");
	chk_loss_stop: assert property ( // R2
		loss_evt |=> speed_o == 8'h00 && s_r.lost_r)
		else $error("loss did not stop loco");
	chk_horn_start: assert property ( // R3
		seq_horn_on ##1 seq_silent |-> horn_o && s_r.hrun_r)
		else $error("horn timer not running");
	chk_horn_auto_off: assert property ( // R3
		horn_evt |=> !horn_o && !s_r.hrun_r)
		else $error("horn auto off failed");
	chk_bcast_write: assert property ( // R4
		cmd.valid && cmd.kind == RDCC_CMD_PROG && cmd.broadcast &&
		cmd.cv_num == CV_NUM_LOSS && cmd.cv_val <= CV_VAL_MAX
		|=> loss_set == $past(cmd.cv_val[7:0]))
		else $error("broadcast write lost");
	chk_addr_discard: assert property ( // R6
		cmd.valid && cmd.kind == RDCC_CMD_PROG && !cmd.broadcast &&
		!hit |=> $stable(loco_r) && $stable(loss_set))
		else $error("foreign write applied");
	chk_addr_match: assert property ( // R8
		cmd.valid && cmd.kind == RDCC_CMD_THROTTLE && !hit && !loss_evt
		|=> $stable(speed_o))
		else $error("foreign throttle applied");
	chk_addr_range: assert property ( // R9
		cmd.valid && cmd.kind == RDCC_CMD_PROG && cmd.broadcast &&
		cmd.cv_num == CV_NUM_ADDR && cmd.cv_val > LOCO_MAX
		|=> $stable(loco_r) && s_r.status_r[ST_PROG_BAD])
		else $error("address out of range stored");
	chk_restore_addr: assert property ( // R10
		cmd.valid && cmd.kind == RDCC_CMD_RESTORE && cmd.broadcast
		|=> loco_r == LOCO_DEF && loss_set == CV_DEF)
		else $error("restore wrong address");
	chk_thermal_latch: assert property ( // R12
		overtemp |=> !drv_en_o ##1 !drv_en_o)
		else $error("drivers not latched off");
	chk_loss_restart: assert property ( // R14
		thr_hit |=> s_r.lsec_r == 8'h00 && s_r.tick_r == '0 && !s_r.lost_r)
		else $error("loss timer not restarted");
	chk_horn_cancel: assert property ( // R15
		cmd.valid && !(thr_hit && cmd.horn) |=> !s_r.hrun_r)
		else $error("horn delay not cancelled");

endmodule // rdcc_top
